/* File: pkg/mgt_pkg.sv */
/*
  Constants of the startup sequencer and gate turn-off block: register offsets,
  field positions, reset values and the startup timing figures.
  Assumes a 50 MHz system clock and a word-aligned plain register port.
*/
package mgt_pkg;

  // ---------------------------------------------------------------
  // Clock and timing figures.
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 50000000;            // System clock rate in hertz.
  localparam int CYC_PER_MS = CLK_HZ / 1000;   // Cycles in one millisecond.
  localparam int CYC_PER_US = CLK_HZ / 1000000; // Cycles in one microsecond.
  localparam int MS_W = 10;                    // Width of the millisecond counter.

  localparam logic [MS_W-1:0] T_AUX_REG_MS = 10'd20;      // Aux regulator on.
  localparam logic [MS_W-1:0] T_INIT_START_MS = 10'd22;   // Init started.
  localparam logic [MS_W-1:0] T_INIT_DONE_SLOW_MS = 10'd69; // Init done, normal speed.
  localparam logic [MS_W-1:0] T_INIT_DONE_FAST_MS = 10'd47; // Init done, fast speed.
  localparam logic [MS_W-1:0] T_FULL_SCAN_SLOW_MS = 10'd164; // Full scan, normal speed.
  localparam logic [MS_W-1:0] T_FULL_SCAN_FAST_MS = 10'd97;  // Full scan, fast speed.
  localparam logic [MS_W-1:0] T_SWITCH_SLOW_MS = 10'd282; // Switches on, normal speed.
  localparam logic [MS_W-1:0] T_SWITCH_FAST_MS = 10'd283; // Switches on, fast speed.
  localparam logic [MS_W-1:0] T_EVAL_PERIOD_MS = 10'd250; // Switch decision period.

  localparam int PULSE_MIN_US = 100;           // Shortest pulsing window in microseconds.
  localparam int PULSE_MAX_US = 200;           // Longest pulsing window in microseconds.
  localparam int PULSE_CYC = PULSE_MIN_US * CYC_PER_US; // Window in cycles, at the shortest length.

  // ---------------------------------------------------------------
  // Register map.
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;                   // Register address width.
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00; // Control register.
  localparam logic [ADDR_W-1:0] OFS_ROUTE = 8'h04;   // Alert routing mask.
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;  // Progress flags and state.

  // Control register fields.
  localparam int CTL_FAST_BIT = 0;     // fast_conversion_select.
  localparam int CTL_AUTO_BIT = 1;     // autonomous_switch_control.
  localparam int CTL_AUXREG_BIT = 2;   // Auto power of first_aux_regulator.
  localparam int CTL_CHG_OFF_BIT = 3;  // Charge switch turn-off command.
  localparam int CTL_DIS_OFF_BIT = 4;  // Discharge switch turn-off command.
  localparam int CTL_SHUT_BIT = 5;     // Write one to return to shutdown.
  localparam int CTL_W = 5;            // Stored control bits.
  localparam logic [CTL_W-1:0] CTL_RESET = 5'h06; // Auto switching and aux regulator on.

  // Flag positions, shared by the routing mask and the status register.
  localparam int FLG_INIT_START = 0;   // init_started_flag.
  localparam int FLG_INIT_DONE = 1;    // init_complete_flag.
  localparam int FLG_VSCAN = 2;        // voltage_scan_done_flag.
  localparam int FLG_FULL = 3;         // full_scan_done_flag.
  localparam int FLG_W = 4;            // Number of progress flags.
  localparam logic [FLG_W-1:0] ROUTE_RESET = 4'h0; // No flag routed after reset.

  // Status register fields above the flags.
  localparam int STS_STATE_LSB = 4;    // Two-bit sequencer state.
  localparam int STS_CHG_BIT = 6;      // Charge switch on.
  localparam int STS_DIS_BIT = 7;      // Discharge switch on.
  localparam int STS_AUX_BIT = 8;      // Aux regulator on.

  // Sequencer states.
  typedef enum logic [1:0] {MGT_SHUTDOWN, MGT_STARTUP, MGT_NORMAL} mgt_state_e;

  // Discharge driver turn-off states.
  typedef enum logic [1:0] {MGT_DIS_ON, MGT_DIS_PULSE, MGT_DIS_HIZ} mgt_dis_e;

endpackage

/* File: hdl/mgt_tick.sv */
/*
  Millisecond tick generator for the startup sequencer.
  Assumes one clock; the count restarts from zero whenever run is low.
*/
`timescale 1ns/1ps
module mgt_tick #(
  parameter int CYC_PER_TICK = 50000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  output logic tick
);

  // Cycle counter, wide enough for the default and shortened periods.
  logic [31:0] cyc;

  // ---------------------------------------------------------------
  // Divider.
  // ---------------------------------------------------------------
  // Counts cycles while running and pulses tick for one cycle per period.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc <= 32'h0;
      tick <= 1'b0;
    end else if (!run) begin
      // Stopped: the next period starts clean on the next run.
      cyc <= 32'h0;
      tick <= 1'b0;
    end else if (cyc == 32'(CYC_PER_TICK - 1)) begin
      cyc <= 32'h0;
      tick <= 1'b1;
    end else begin
      cyc <= cyc + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule

/* File: hdl/mgt_top.sv */
/*
  Startup sequencer and gate turn-off control of a battery monitor.
  Assumes inputs synchronous to SYS_CLK, comparator inputs from the analog
  gate driver, and a plain register port with read data one cycle later.
*/
`timescale 1ns/1ps
module mgt_top
  import mgt_pkg::*;
#(
  parameter int CYC_PER_MS_P = mgt_pkg::CYC_PER_MS,
  parameter int PULSE_CYC_P = mgt_pkg::PULSE_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic [mgt_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic SECOND_THERMISTOR_PIN,
  input wire logic LOAD_DETECT_PIN,
  input wire logic DISCHARGE_GATE_BELOW_LOAD,
  input wire logic DISCHARGE_GATE_NEAR_LOAD,
  output logic FIRST_AUX_REGULATOR_ON,
  output logic ALERT,
  output logic CHARGE_GATE_DRIVE_ON,
  output logic CHARGE_GATE_CLAMP,
  output logic DISCHARGE_GATE_DRIVE_ON,
  output logic DISCHARGE_GATE_PULL_LOW,
  output logic DISCHARGE_GATE_HIZ
);

  // ---------------------------------------------------------------
  // Declarations.
  // ---------------------------------------------------------------
  mgt_state_e state;            // Sequencer state.
  mgt_dis_e dis_state;          // Discharge driver turn-off state.
  logic [CTL_W-1:0] ctl;        // Stored control bits.
  logic [FLG_W-1:0] route;      // Flags routed to the alert output.
  logic [FLG_W-1:0] flags;      // Sticky progress flags.
  logic [MS_W-1:0] ms_cnt;      // Milliseconds since wakeup, saturating.
  logic [MS_W-1:0] eval_cnt;    // Milliseconds to the next switch decision.
  logic [15:0] pulse_cnt;       // Cycles left in the pulsing window.
  logic ms_tick;                // One-cycle pulse per millisecond.
  logic wake_req;               // A wakeup condition is present.
  logic shut_req;               // Software asks for shutdown.
  logic at_ms;                  // A tick that lands on the next millisecond.
  logic [MS_W-1:0] next_ms;     // Millisecond count after this tick.
  logic eval_evt;               // Switch decision instant.
  logic chg_on;                 // Charge switch enabled.
  logic dis_on;                 // Discharge switch enabled.
  logic dis_on_d;               // Discharge switch enable one cycle ago.
  logic ctl_wr;                 // Write to the control register.
  logic sts_wr;                 // Write to the status register.

  // Selects the timing figure for the conversion speed in use.
  function automatic logic [MS_W-1:0] pick_ms(input logic fast,
                                              input logic [MS_W-1:0] t_slow,
                                              input logic [MS_W-1:0] t_fast);
    pick_ms = fast ? t_fast : t_slow;
  endfunction

  // ---------------------------------------------------------------
  // Millisecond time base.
  // ---------------------------------------------------------------
  // The divider only runs while awake, so time zero is the wakeup.
  mgt_tick #(
    .CYC_PER_TICK(CYC_PER_MS_P)
  ) u_tick (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .run(state != MGT_SHUTDOWN),
    .tick(ms_tick)
  );

  // Wakeup from the thermistor pin pulled low or the load pin pulled up.
  assign wake_req = !SECOND_THERMISTOR_PIN || LOAD_DETECT_PIN;
  assign shut_req = REG_WR && (REG_ADDR == OFS_CONTROL) && REG_WDATA[CTL_SHUT_BIT];
  assign ctl_wr = REG_WR && (REG_ADDR == OFS_CONTROL);
  assign sts_wr = REG_WR && (REG_ADDR == OFS_STATUS);
  assign next_ms = (ms_cnt == {MS_W{1'b1}}) ? ms_cnt : ms_cnt + 10'h001;
  assign at_ms = ms_tick && (state != MGT_SHUTDOWN);
  // A decision is taken only when the period counter expires in normal mode.
  assign eval_evt = at_ms && (state == MGT_NORMAL) && (eval_cnt == 10'h001);

  // Counts milliseconds from the wakeup; restarts at each wakeup.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ms_cnt <= 10'h000;
    end else if (state == MGT_SHUTDOWN) begin
      ms_cnt <= 10'h000;
    end else if (at_ms) begin
      ms_cnt <= next_ms;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer.
  // ---------------------------------------------------------------
  // Shutdown, startup scans, then normal mode at the full scan.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state <= MGT_SHUTDOWN;
    end else if (shut_req) begin
      // Software shutdown wins over every other step.
      state <= MGT_SHUTDOWN;
    end else begin
      case (state)
        MGT_SHUTDOWN: begin
          if (wake_req) begin
            state <= MGT_STARTUP;
          end
        end
        MGT_STARTUP: begin
          // Normal mode begins once the full scan is done.
          if (at_ms && next_ms == pick_ms(ctl[CTL_FAST_BIT], T_FULL_SCAN_SLOW_MS,
                                          T_FULL_SCAN_FAST_MS)) begin
            state <= MGT_NORMAL;
          end
        end
        MGT_NORMAL: begin
          state <= MGT_NORMAL;
        end
        default: begin
          state <= MGT_SHUTDOWN;
        end
      endcase
    end
  end

  // Sets the progress flags at their instants; set wins over a clear.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flags <= {FLG_W{1'b0}};
    end else if (state == MGT_SHUTDOWN) begin
      flags <= {FLG_W{1'b0}};
    end else begin
      // Write one to a status flag bit clears it.
      if (sts_wr) begin
        flags <= flags & ~REG_WDATA[FLG_W-1:0];
      end
      if (at_ms && next_ms == T_INIT_START_MS) begin
        flags[FLG_INIT_START] <= 1'b1;
      end
      if (at_ms && next_ms == pick_ms(ctl[CTL_FAST_BIT], T_INIT_DONE_SLOW_MS,
                                      T_INIT_DONE_FAST_MS)) begin
        flags[FLG_INIT_DONE] <= 1'b1;
        flags[FLG_VSCAN] <= 1'b1;
      end
      if (at_ms && next_ms == pick_ms(ctl[CTL_FAST_BIT], T_FULL_SCAN_SLOW_MS,
                                      T_FULL_SCAN_FAST_MS)) begin
        flags[FLG_FULL] <= 1'b1;
      end
    end
  end

  // Powers the aux regulator at its instant when configured.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FIRST_AUX_REGULATOR_ON <= 1'b0;
    end else if (state == MGT_SHUTDOWN) begin
      FIRST_AUX_REGULATOR_ON <= 1'b0;
    end else if (at_ms && next_ms == T_AUX_REG_MS && ctl[CTL_AUXREG_BIT]) begin
      FIRST_AUX_REGULATOR_ON <= 1'b1;
    end
  end

  // Drives the alert with the routed flags only.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ALERT <= 1'b0;
    end else begin
      ALERT <= |(flags & route);
    end
  end

  // ---------------------------------------------------------------
  // Switch decision.
  // ---------------------------------------------------------------
  // Loads the first decision delay at normal entry, then the 250 ms period.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      eval_cnt <= 10'h000;
    end else if (state == MGT_STARTUP) begin
      // The first decision lands at the documented switch-on instant.
      eval_cnt <= pick_ms(ctl[CTL_FAST_BIT], T_SWITCH_SLOW_MS - T_FULL_SCAN_SLOW_MS,
                          T_SWITCH_FAST_MS - T_FULL_SCAN_FAST_MS);
    end else if (eval_evt) begin
      eval_cnt <= T_EVAL_PERIOD_MS;
    end else if (at_ms && state == MGT_NORMAL) begin
      eval_cnt <= eval_cnt - 10'h001;
    end
  end

  // Turns switches on at a decision; an off command turns them off at once.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      chg_on <= 1'b0;
      dis_on <= 1'b0;
    end else if (state != MGT_NORMAL) begin
      chg_on <= 1'b0;
      dis_on <= 1'b0;
    end else begin
      if (ctl[CTL_CHG_OFF_BIT]) begin
        chg_on <= 1'b0;
      end else if (eval_evt && ctl[CTL_AUTO_BIT]) begin
        chg_on <= 1'b1;
      end
      if (ctl[CTL_DIS_OFF_BIT]) begin
        dis_on <= 1'b0;
      end else if (eval_evt && ctl[CTL_AUTO_BIT]) begin
        dis_on <= 1'b1;
      end
    end
  end

  // Charge driver: pump while on, clamp to the stack supply while off.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      CHARGE_GATE_DRIVE_ON <= 1'b0;
      CHARGE_GATE_CLAMP <= 1'b1;
    end else begin
      CHARGE_GATE_DRIVE_ON <= chg_on;
      CHARGE_GATE_CLAMP <= !chg_on;
    end
  end

  // ---------------------------------------------------------------
  // Discharge driver turn-off.
  // ---------------------------------------------------------------
  // Remembers the previous enable; no logic reads it for the turn-off edge.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dis_on_d <= 1'b0;
    end else begin
      dis_on_d <= dis_on;
    end
  end

  // Pulses against the load level for the window, then parks high impedance.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      dis_state <= MGT_DIS_HIZ;
      pulse_cnt <= 16'h0000;
    end else begin
      case (dis_state)
        MGT_DIS_ON: begin
          if (!dis_on) begin
            dis_state <= MGT_DIS_PULSE;
            pulse_cnt <= 16'(PULSE_CYC_P);
          end
        end
        MGT_DIS_PULSE: begin
          if (dis_on) begin
            dis_state <= MGT_DIS_ON;
          end else if (pulse_cnt != 16'h0000) begin
            pulse_cnt <= pulse_cnt - 16'h0001;
          end else if (DISCHARGE_GATE_NEAR_LOAD) begin
            // Past the window and settled near the load level.
            dis_state <= MGT_DIS_HIZ;
          end
        end
        MGT_DIS_HIZ: begin
          if (dis_on) begin
            dis_state <= MGT_DIS_ON;
          end
        end
        default: begin
          dis_state <= MGT_DIS_HIZ;
        end
      endcase
    end
  end

  // Pull low only while pulsing and the gate sits above the load level.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DISCHARGE_GATE_DRIVE_ON <= 1'b0;
      DISCHARGE_GATE_PULL_LOW <= 1'b0;
      DISCHARGE_GATE_HIZ <= 1'b1;
    end else begin
      DISCHARGE_GATE_DRIVE_ON <= (dis_state == MGT_DIS_ON) && dis_on;
      DISCHARGE_GATE_PULL_LOW <= (dis_state == MGT_DIS_PULSE) && !dis_on
                                 && !DISCHARGE_GATE_BELOW_LOAD;
      DISCHARGE_GATE_HIZ <= (dis_state == MGT_DIS_HIZ) && !dis_on;
    end
  end

  // ---------------------------------------------------------------
  // Register port.
  // ---------------------------------------------------------------
  // Stores control bits; the shutdown bit is a strobe and is not kept.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctl <= CTL_RESET;
      route <= ROUTE_RESET;
    end else begin
      if (ctl_wr) begin
        ctl <= REG_WDATA[CTL_W-1:0];
      end
      if (REG_WR && REG_ADDR == OFS_ROUTE) begin
        route <= REG_WDATA[FLG_W-1:0];
      end
    end
  end

  // Returns read data in the cycle after the read strobe and only there.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 32'h0000_0000;
    end else if (!REG_RD) begin
      REG_RDATA <= 32'h0000_0000;
    end else begin
      case (REG_ADDR)
        OFS_CONTROL: REG_RDATA <= {27'h0, ctl};
        OFS_ROUTE: REG_RDATA <= {28'h0, route};
        OFS_STATUS: REG_RDATA <= {23'h0, FIRST_AUX_REGULATOR_ON, dis_on, chg_on,
                                  state, flags};
        default: REG_RDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------
  chk_wake_entry: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    (state == MGT_SHUTDOWN && wake_req && !shut_req) |=> (state == MGT_STARTUP && ms_cnt == 0))
    else $error("Wakeup did not start the sequence.");

  chk_normal_entry: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    (state == MGT_NORMAL && $past(state) == MGT_STARTUP) |-> flags[FLG_FULL]
      && (ms_cnt == pick_ms(ctl[CTL_FAST_BIT], T_FULL_SCAN_SLOW_MS, T_FULL_SCAN_FAST_MS)))
    else $error("Normal mode entered before the full scan.");

  chk_aux_time: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    $rose(FIRST_AUX_REGULATOR_ON) |-> (ms_cnt == T_AUX_REG_MS))
    else $error("Aux regulator came on at the wrong time.");

  chk_init_start: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    $rose(flags[FLG_INIT_START]) |-> (ms_cnt == T_INIT_START_MS))
    else $error("Init-started flag at the wrong time.");

  chk_init_pair: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    $rose(flags[FLG_INIT_DONE]) |-> flags[FLG_VSCAN]
      && (ms_cnt == pick_ms(ctl[CTL_FAST_BIT], T_INIT_DONE_SLOW_MS, T_INIT_DONE_FAST_MS)))
    else $error("Init-done flags not set together on time.");

  chk_full_scan: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    $rose(flags[FLG_FULL]) |-> (ms_cnt ==
      pick_ms(ctl[CTL_FAST_BIT], T_FULL_SCAN_SLOW_MS, T_FULL_SCAN_FAST_MS)))
    else $error("Full-scan flag at the wrong time.");

  chk_switch_decide: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    $rose(chg_on) |-> $past(eval_evt) && $past(ctl[CTL_AUTO_BIT]))
    else $error("Charge switch came on outside a decision.");

  chk_eval_period: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    eval_evt |=> (eval_cnt == T_EVAL_PERIOD_MS))
    else $error("Decision period not reloaded.");

  chk_first_switch: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    ($rose(dis_on) && ms_cnt < T_SWITCH_FAST_MS + 10'h001) |->
      (ms_cnt == pick_ms(ctl[CTL_FAST_BIT], T_SWITCH_SLOW_MS, T_SWITCH_FAST_MS)))
    else $error("First switch-on at the wrong time.");

  chk_charge_clamp: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    $fell(chg_on) |=> CHARGE_GATE_CLAMP && !CHARGE_GATE_DRIVE_ON)
    else $error("Charge clamp not closed after turn-off.");

  chk_pull_stop: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    (dis_state == MGT_DIS_PULSE && !dis_on && DISCHARGE_GATE_BELOW_LOAD) |=>
      !DISCHARGE_GATE_PULL_LOW)
    else $error("Discharge pull not halted below the load level.");

  chk_pull_resume: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    (dis_state == MGT_DIS_PULSE && !dis_on && !DISCHARGE_GATE_BELOW_LOAD) |=>
      DISCHARGE_GATE_PULL_LOW)
    else $error("Discharge pull not resumed above the load level.");

  chk_hiz_window: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    (dis_state == MGT_DIS_HIZ && $past(dis_state) == MGT_DIS_PULSE) |->
      $past(pulse_cnt) == 16'h0000 && $past(DISCHARGE_GATE_NEAR_LOAD))
    else $error("High impedance entered early or away from the load level.");

  chk_alert_route: assert property (
    @(posedge SYS_CLK) disable iff (!RST_B)
    ALERT |-> |($past(flags) & $past(route)))
    else $error("Alert raised by an unrouted flag.");

endmodule

/* File: tb/mgt_gate_model.sv */
/*
  Far-side model of the discharge switch gate and its two comparators.
  Assumes the driver strobes of mgt_top on the same clock.
*/
`timescale 1ns/1ps
module mgt_gate_model (
  input wire logic clk,
  input wire logic drive_on,
  input wire logic pull_low,
  output logic below_load,
  output logic near_load
);
  // Gate level in coarse steps; the load level sits at eight.
  int g = 9;
  // The pump charges, the pull drains, a released gate relaxes upward.
  always @(posedge clk) begin
    if (drive_on) begin
      g <= 20;
    end else if (pull_low) begin
      g <= g - 3;
    end else if (g < 10) begin
      g <= g + 1;
    end
  end
  assign below_load = (g < 8);
  assign near_load = (g > 4) && (g < 12);
endmodule

/* File: tb/tb_mgt_top.sv */
/*
  Testbench of the startup sequencer and gate turn-off block.
  Assumes one clock and the gate model on the discharge comparators.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb_mgt_top;
  import mgt_pkg::*;
  // Cycles per millisecond, and a pulsing window long enough for a pulse train.
  localparam int M = 20;
  localparam int P = 30;
  logic SYS_CLK = 0, RST_B = 0, REG_WR = 0, REG_RD = 0, THERM = 1, LOAD = 0, pv;
  logic [7:0] REG_ADDR = 0;
  logic [31:0] REG_WDATA = 0, REG_RDATA, d;
  logic below, near, AUX, ALERT, CDRV, CLAMP, DDRV, PULL, HIZ;
  int failures = 0, samples_checked = 0, cnt = 0, w = 0, n, k, p;
  int ms[15] = '{19, 21, 23, 68, 70, 163, 165, 281, 284, 46, 48, 96, 98, 282, 285};
  logic [8:0] st[15] = '{9'h010, 9'h110, 9'h111, 9'h111, 9'h117, 9'h117, 9'h12f,
    9'h12f, 9'h1ef, 9'h111, 9'h117, 9'h117, 9'h12f, 9'h12f, 9'h1af};
  always #10 SYS_CLK = ~SYS_CLK;
  always @(posedge SYS_CLK) cnt <= cnt + 1;
  mgt_top #(.CYC_PER_MS_P(M), .PULSE_CYC_P(P)) mgt_top_inst (.SYS_CLK(SYS_CLK),
    .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SECOND_THERMISTOR_PIN(THERM),
    .LOAD_DETECT_PIN(LOAD), .DISCHARGE_GATE_BELOW_LOAD(below),
    .DISCHARGE_GATE_NEAR_LOAD(near), .FIRST_AUX_REGULATOR_ON(AUX), .ALERT(ALERT),
    .CHARGE_GATE_DRIVE_ON(CDRV), .CHARGE_GATE_CLAMP(CLAMP),
    .DISCHARGE_GATE_DRIVE_ON(DDRV), .DISCHARGE_GATE_PULL_LOW(PULL),
    .DISCHARGE_GATE_HIZ(HIZ));
  mgt_gate_model mgt_gate_model_inst (.clk(SYS_CLK), .drive_on(DDRV),
    .pull_low(PULL), .below_load(below), .near_load(near));
  // One-cycle register write.
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  // One-cycle register read; data is taken in the following cycle.
  task rd(input logic [7:0] a);
    @(posedge SYS_CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  // Waits until a few cycles past the given millisecond after wakeup.
  task at(input int t);
    repeat (w + t * M + 3 - cnt) @(posedge SYS_CLK);
  endtask
  // Reads status at each listed time and checks flags, state and alert.
  task run(input int lo, input int hi);
    for (n = lo; n <= hi; n++) begin
      at(ms[n]);
      rd(OFS_STATUS);
      `CHK(d[8:0], st[n])
      `CHK(ALERT, st[n][2])
      `CHK(AUX, st[n][8])
      `CHK(CDRV, st[n][6])
      `CHK(CLAMP, !st[n][6])
      `CHK(DDRV, st[n][7])
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rd(OFS_CONTROL);
    `CHK(d, 32'h6)
    `CHK(HIZ, 1'b1)
    wr(8'h0c, 32'hff);
    rd(8'h0c);
    `CHK(d, 32'h0)
    wr(OFS_ROUTE, 32'h4);
    @(posedge SYS_CLK);
    THERM <= 1'b0;
    #1 w = cnt;
    run(0, 8);
    `CHK(CLAMP, 1'b0)
    @(posedge SYS_CLK);
    THERM <= 1'b1;
    wr(OFS_CONTROL, 32'h20);
    p = 0;
    pv = 1'b0;
    for (k = 0; k < 300 && HIZ !== 1'b1; k++) begin
      @(posedge SYS_CLK);
      #1 if (PULL === 1'b1 && pv !== 1'b1) p++;
      pv = PULL;
    end
    `CHK(k >= P + 4 && k < 300, 1'b1)
    `CHK(p >= 2, 1'b1)
    `CHK(CLAMP, 1'b1)
    rd(OFS_STATUS);
    `CHK(d[8:0], 9'h000)
    wr(OFS_CONTROL, 32'h0f);
    @(posedge SYS_CLK);
    LOAD <= 1'b1;
    #1 w = cnt;
    run(9, 14);
    at(290);
    wr(OFS_CONTROL, 32'h07);
    at(300);
    rd(OFS_STATUS);
    `CHK(d[8:0], 9'h1af)
    // The next decision, one period after the first, turns the charge switch on.
    at(534);
    rd(OFS_STATUS);
    `CHK(d[8:0], 9'h1ef)
    `CHK(CDRV, 1'b1)
    final_report();
  end
endmodule
